// File: hw/flp_apb_port.sv
`include "flp_consts.svh"

module flp_apb_port
    import flp_pkg::*;
#(
    parameter int AW = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    flp_reg_if.slave rif
);
    flp_apb_st_t s_r;
    flp_apb_st_t s_nxt;

    generate
        if (AW < 6 || AW > 16)
        begin : gen_bad_aw
            $error("flp_apb_port: AW must lie in 6..16");
        end
    endgenerate

    always_comb
    begin
        rif.idx = paddr[4:2];
        rif.hit = (paddr[AW-1:5] == '0) && (paddr[1:0] == 2'h0)
            && (paddr[4:2] <= `FLP_REG_LAST);
        rif.wr = psel && penable && pwrite && rif.hit;
        rif.wdata = pwdata;
        s_nxt = s_r;
        // Read data is fetched in setup so the access phase needs no wait
        if (psel && !penable)
        begin
            s_nxt.prdata = (rif.hit && !pwrite) ? rif.rdata : 32'h0000_0000;
            s_nxt.slverr = !rif.hit;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pslverr = s_r.slverr && psel && penable;
    assign pready = 1'b1;
endmodule

// File: hw/flp_consts.svh
`ifndef FLP_CONSTS_SVH
`define FLP_CONSTS_SVH

// Code space map
`define FLP_APP_BASE 16'h0000
`define FLP_APP_SIZE 16'h4000
`define FLP_FCFG1_BASE 16'h4000
`define FLP_FCFG1_SIZE 16'h0280
`define FLP_FCFG2_BASE 16'h4400
`define FLP_FCFG2_SIZE 16'h0200
`define FLP_UCFG_BASE 16'h4600
`define FLP_UCFG_SIZE 16'h0200
`define FLP_ROM_BASE 16'h8000
`define FLP_ROM_SIZE 16'h8000
`define FLP_PAGE_LSB 9
`define FLP_PAGES 32
`define FLP_LINE_MASK 16'h003F

// Lock byte locations and slots
`define FLP_LA_FCFG1 16'h427F
`define FLP_LA_CODE_LO 16'h3FFE
`define FLP_LA_CODE_HI 16'h3FFF
`define FLP_LA_UCFG 16'h47FF
`define FLP_LA_FCFG2 16'h45FF
`define FLP_LK_FCFG1 3'h0
`define FLP_LK_CODE_LO 3'h1
`define FLP_LK_CODE_HI 3'h2
`define FLP_LK_UCFG 3'h3
`define FLP_LK_FCFG2 3'h4
`define FLP_LK_LAST 3'h4
`define FLP_UNLOCKED 8'hFF
`define FLP_LOCK_RST 8'h00

// Register indices (byte address is four times the index)
`define FLP_REG_LOCKS 3'h0
`define FLP_REG_STATUS 3'h1
`define FLP_REG_PMASK 3'h2
`define FLP_REG_VIOL 3'h3
`define FLP_REG_CTRL 3'h4
`define FLP_REG_LAST 3'h4
`define FLP_CTRL_LOG_RST 1'b1
`endif

// File: hw/flp_lock_guard.sv
`include "flp_consts.svh"

module flp_lock_guard
    import flp_pkg::*;
#(
    parameter int APB_AW = 8
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [APB_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic FL_RD_EN,
    output logic [15:0] FL_RD_ADDR,
    input wire logic [7:0] FL_RD_DATA,
    input wire logic REQ_VALID,
    input wire logic [1:0] REQ_OP,
    input wire logic [15:0] REQ_ADDR,
    input wire logic REQ_PROG_MODE,
    input wire logic REQ_TEST_MODE,
    output logic REQ_READY,
    output logic ACC_GRANT,
    output logic ACC_DENY,
    output logic MODE_LIMITED
);
    flp_core_st_t s_r;
    flp_core_st_t s_nxt;
    flp_reg_if rif ();

    logic ready;
    logic [31:0] page_mask;
    logic code_active;
    logic code_invalid;
    flp_region_t region;
    flp_op_t op;
    logic [4:0] page;
    logic page_locked;
    logic line_ok;
    logic allow;
    logic fcfg1_open;
    logic fcfg2_open;
    logic ucfg_open;
    logic log_hit;

    generate
        if (APB_AW < 6 || APB_AW > 16)
        begin : gen_bad_aw
            $error("flp_lock_guard: APB_AW must lie in 6..16");
        end
    endgenerate

    flp_apb_port #(
        .AW(APB_AW)
    ) u_apb (
        .clk(CLK),
        .rst_n(RST_N),
        .psel(PSEL),
        .penable(PENABLE),
        .pwrite(PWRITE),
        .paddr(PADDR),
        .pwdata(PWDATA),
        .prdata(PRDATA),
        .pready(PREADY),
        .pslverr(PSLVERR),
        .rif(rif.slave)
    );

    flp_page_map u_pages (
        .lock_lo(s_r.lock[`FLP_LK_CODE_LO]),
        .lock_hi(s_r.lock[`FLP_LK_CODE_HI]),
        .mask(page_mask),
        .active(code_active),
        .invalid(code_invalid)
    );

    // Each lock byte sits at the end of the sector it guards; the two code locks take its last two bytes
    function automatic logic [15:0] lock_loc(input logic [2:0] slot);
        logic [15:0] a;
        a = `FLP_LA_FCFG1;
        case (slot)
            `FLP_LK_FCFG1: a = `FLP_LA_FCFG1;
            `FLP_LK_CODE_LO: a = `FLP_LA_CODE_LO;
            `FLP_LK_CODE_HI: a = `FLP_LA_CODE_HI;
            `FLP_LK_UCFG: a = `FLP_LA_UCFG;
            `FLP_LK_FCFG2: a = `FLP_LA_FCFG2;
            default: a = `FLP_LA_FCFG1;
        endcase
        return a;
    endfunction

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] base,
        input logic [15:0] size);
        logic [16:0] top;
        top = {1'b0, base} + {1'b0, size};
        return ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top);
    endfunction

    assign ready = (s_r.st == FLP_ST_ACTIVE);
    assign op = flp_op_t'(REQ_OP);

    // Address map of the code space
    always_comb
    begin
        if (in_range(REQ_ADDR, `FLP_APP_BASE, `FLP_APP_SIZE))
        begin
            region = FLP_RG_APP;
        end
        else if (in_range(REQ_ADDR, `FLP_FCFG1_BASE, `FLP_FCFG1_SIZE))
        begin
            region = FLP_RG_FCFG1;
        end
        else if (in_range(REQ_ADDR, `FLP_FCFG2_BASE, `FLP_FCFG2_SIZE))
        begin
            region = FLP_RG_FCFG2;
        end
        else if (in_range(REQ_ADDR, `FLP_UCFG_BASE, `FLP_UCFG_SIZE))
        begin
            region = FLP_RG_UCFG;
        end
        else if (in_range(REQ_ADDR, `FLP_ROM_BASE, `FLP_ROM_SIZE))
        begin
            region = FLP_RG_ROM;
        end
        else
        begin
            region = FLP_RG_NONE;
        end
    end

    assign page = REQ_ADDR[`FLP_PAGE_LSB +: 5];
    assign page_locked = page_mask[page];
    // Program mode writes whole 64-byte lines only
    assign line_ok = !REQ_PROG_MODE || ((REQ_ADDR & `FLP_LINE_MASK) == 16'h0000);
    assign fcfg1_open = (s_r.lock[`FLP_LK_FCFG1] == `FLP_UNLOCKED);
    assign fcfg2_open = (s_r.lock[`FLP_LK_FCFG2] == `FLP_UNLOCKED);
    assign ucfg_open = (s_r.lock[`FLP_LK_UCFG] == `FLP_UNLOCKED);

    // Permission check against the reset-time lock copy
    always_comb
    begin
        allow = 1'b0;
        case (region)
            FLP_RG_APP:
            begin
                case (op)
                    // Read-out refused to the programming path on locked pages
                    FLP_OP_READ: allow = !(REQ_PROG_MODE && page_locked);
                    FLP_OP_WRITE: allow = !page_locked && line_ok;
                    // Sector erase wipes the whole sector, so any locked page refuses it outside test mode
                    FLP_OP_WIPE: allow = REQ_TEST_MODE || (page_mask == 32'h0000_0000);
                    FLP_OP_CHIP: allow = REQ_PROG_MODE;
                    default: allow = 1'b0;
                endcase
            end
            FLP_RG_FCFG1:
            begin
                // Factory data never changes; reads follow its own lock
                allow = (op == FLP_OP_READ) && fcfg1_open;
            end
            FLP_RG_FCFG2:
            begin
                allow = (op == FLP_OP_READ) && fcfg2_open;
            end
            FLP_RG_UCFG:
            begin
                case (op)
                    FLP_OP_READ: allow = 1'b1;
                    // Follows its own lock in either mode, lock byte location included
                    FLP_OP_WRITE: allow = ucfg_open && line_ok;
                    FLP_OP_WIPE: allow = ucfg_open || REQ_TEST_MODE;
                    FLP_OP_CHIP: allow = REQ_PROG_MODE;
                    default: allow = 1'b0;
                endcase
            end
            FLP_RG_ROM:
            begin
                allow = (op == FLP_OP_READ);
            end
            default:
            begin
                allow = 1'b0;
            end
        endcase
    end

    // Refused operations never reach the array; the requester sees a deny
    assign REQ_READY = ready;
    assign ACC_GRANT = REQ_VALID && ready && allow;
    assign ACC_DENY = REQ_VALID && ready && !allow;
    assign MODE_LIMITED = ready && code_active;
    assign FL_RD_EN = s_r.rd_en;
    assign FL_RD_ADDR = s_r.rd_addr;
    assign log_hit = ACC_DENY && s_r.log_en;

    // Register read view
    always_comb
    begin
        rif.rdata = 32'h0000_0000;
        case (rif.idx)
            `FLP_REG_LOCKS:
            begin
                rif.rdata = {s_r.lock[`FLP_LK_UCFG], s_r.lock[`FLP_LK_CODE_HI],
                    s_r.lock[`FLP_LK_CODE_LO], s_r.lock[`FLP_LK_FCFG1]};
            end
            `FLP_REG_STATUS:
            begin
                rif.rdata = {20'h00000, MODE_LIMITED, code_invalid, code_active, ready,
                    s_r.lock[`FLP_LK_FCFG2]};
            end
            `FLP_REG_PMASK:
            begin
                rif.rdata = ready ? page_mask : 32'h0000_0000;
            end
            `FLP_REG_VIOL:
            begin
                rif.rdata = {s_r.viol_addr, 12'h000, s_r.viol_prog, s_r.viol_op, s_r.viol};
            end
            `FLP_REG_CTRL:
            begin
                rif.rdata = {31'h0000_0000, s_r.log_en};
            end
            default:
            begin
                rif.rdata = 32'h0000_0000;
            end
        endcase
    end

    // Next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pend = s_r.rd_en;
        s_nxt.pidx = s_r.ridx;
        case (s_r.st)
            FLP_ST_IDLE:
            begin
                s_nxt.st = FLP_ST_FETCH;
                s_nxt.rd_en = 1'b1;
                s_nxt.ridx = 3'h0;
                s_nxt.rd_addr = lock_loc(3'h0);
            end
            FLP_ST_FETCH:
            begin
                if (s_r.rd_en && (s_r.ridx != `FLP_LK_LAST))
                begin
                    s_nxt.ridx = s_r.ridx + 3'h1;
                    s_nxt.rd_addr = lock_loc(s_r.ridx + 3'h1);
                end
                else
                begin
                    s_nxt.rd_en = 1'b0;
                end
                // Flash answers one cycle after it takes the address
                if (s_r.pend)
                begin
                    s_nxt.lock[s_r.pidx] = FL_RD_DATA;
                    if (s_r.pidx == `FLP_LK_LAST)
                    begin
                        s_nxt.st = FLP_ST_ACTIVE;
                    end
                end
            end
            FLP_ST_ACTIVE:
            begin
                // Locks stay frozen here; new flash values need a reset
                s_nxt.rd_en = 1'b0;
            end
            default:
            begin
                s_nxt.st = FLP_ST_IDLE;
                s_nxt.rd_en = 1'b0;
            end
        endcase

        if (rif.wr && (rif.idx == `FLP_REG_CTRL))
        begin
            s_nxt.log_en = rif.wdata[0];
        end
        if (rif.wr && (rif.idx == `FLP_REG_VIOL) && rif.wdata[0])
        begin
            s_nxt.viol = 1'b0;
        end
        // A deny in the clearing cycle still sets the flag
        if (log_hit)
        begin
            s_nxt.viol = 1'b1;
            s_nxt.viol_op = op;
            s_nxt.viol_prog = REQ_PROG_MODE;
            s_nxt.viol_addr = REQ_ADDR;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_r.st <= FLP_ST_IDLE;
            s_r.rd_en <= 1'b0;
            s_r.rd_addr <= 16'h0000;
            s_r.ridx <= 3'h0;
            s_r.pend <= 1'b0;
            s_r.pidx <= 3'h0;
            s_r.lock <= {5{`FLP_LOCK_RST}};
            s_r.viol <= 1'b0;
            s_r.viol_op <= FLP_OP_READ;
            s_r.viol_prog <= 1'b0;
            s_r.viol_addr <= 16'h0000;
            s_r.log_en <= `FLP_CTRL_LOG_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule

// File: hw/flp_page_map.sv
`include "flp_consts.svh"

module flp_page_map
(
    input wire logic [7:0] lock_lo,
    input wire logic [7:0] lock_hi,
    output logic [31:0] mask,
    output logic active,
    output logic invalid
);
    logic lo_on;
    logic hi_on;
    logic [7:0] lo_cnt;
    logic [7:0] hi_cnt;

    assign lo_on = (lock_lo != `FLP_UNLOCKED);
    assign hi_on = (lock_hi != `FLP_UNLOCKED);
    // Decrement count below FF gives the number of pages covered
    assign lo_cnt = `FLP_UNLOCKED - lock_lo;
    assign hi_cnt = `FLP_UNLOCKED - lock_hi;
    assign active = lo_on || hi_on;
    // Codes 00..7F are forbidden; they lock everything to fail safe
    assign invalid = (lo_on && !lock_lo[7]) || (hi_on && !lock_hi[7]);

    generate
        for (genvar g = 0; g < `FLP_PAGES; g++)
        begin : gen_page
            localparam logic [7:0] PG = 8'(g);
            localparam logic [7:0] PG_TOP = 8'(`FLP_PAGES - 1 - g);
            logic by_lo;
            logic by_hi;
            assign by_lo = lo_on && (!lock_lo[7] || (PG < lo_cnt));
            assign by_hi = hi_on && (!lock_hi[7] || (PG_TOP < hi_cnt));
            // Top page is always covered once any code lock is set
            assign mask[g] = by_lo || by_hi || (active && (PG_TOP == 8'h00));
        end
    endgenerate
endmodule

// File: hw/flp_pkg.sv
package flp_pkg;
    typedef enum logic [1:0]
    {
        FLP_ST_IDLE = 2'b00,
        FLP_ST_FETCH = 2'b01,
        FLP_ST_ACTIVE = 2'b10
    } flp_state_t;

    typedef enum logic [1:0]
    {
        FLP_OP_READ = 2'b00,
        FLP_OP_WRITE = 2'b01,
        FLP_OP_WIPE = 2'b10,
        FLP_OP_CHIP = 2'b11
    } flp_op_t;

    typedef enum logic [2:0]
    {
        FLP_RG_APP = 3'b000,
        FLP_RG_FCFG1 = 3'b001,
        FLP_RG_FCFG2 = 3'b010,
        FLP_RG_UCFG = 3'b011,
        FLP_RG_ROM = 3'b100,
        FLP_RG_NONE = 3'b101
    } flp_region_t;

    typedef struct packed {
        flp_state_t st;
        logic rd_en;
        logic [15:0] rd_addr;
        logic [2:0] ridx;
        logic pend;
        logic [2:0] pidx;
        logic [4:0][7:0] lock;
        logic viol;
        flp_op_t viol_op;
        logic viol_prog;
        logic [15:0] viol_addr;
        logic log_en;
    } flp_core_st_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic slverr;
    } flp_apb_st_t;
endpackage

// File: hw/flp_reg_if.sv
interface flp_reg_if;
    logic [2:0] idx;
    logic hit;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport slave (output idx, output hit, output wr, output wdata, input rdata);
    modport core (input idx, input hit, input wr, input wdata, output rdata);
endinterface

// File: sim/flp_flash_model.sv
`include "flp_consts.svh"

module flp_flash_model
(
    input wire logic clk,
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    input wire logic [31:0] locks,
    output logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial rd_data = 8'h5A;

    // Data holds one cycle only; then the line wanders so a stale byte never looks valid
    always @(posedge clk)
    begin
        if (!rd_en)
            rd_data <= ~rd_data;
        else if (rd_addr == `FLP_LA_FCFG1 || rd_addr == `FLP_LA_FCFG2)
            rd_data <= locks[7:0];
        else if (rd_addr == `FLP_LA_CODE_LO)
            rd_data <= locks[15:8];
        else if (rd_addr == `FLP_LA_CODE_HI)
            rd_data <= locks[23:16];
        else if (rd_addr == `FLP_LA_UCFG)
            rd_data <= locks[31:24];
        else
            rd_data <= `FLP_UNLOCKED;
    end
endmodule

// File: sim/flp_lock_guard_checker.sv
`include "flp_consts.svh"

module flp_lock_guard_checker
    import flp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic FL_RD_EN,
    input wire logic [15:0] FL_RD_ADDR,
    input wire logic REQ_VALID,
    input wire logic [1:0] REQ_OP,
    input wire logic [15:0] REQ_ADDR,
    input wire logic REQ_PROG_MODE,
    input wire logic REQ_TEST_MODE,
    input wire logic REQ_READY,
    input wire logic ACC_GRANT,
    input wire logic ACC_DENY,
    input wire logic MODE_LIMITED
);
    timeunit 1ns;
    timeprecision 100ps;

    wire logic live = REQ_VALID && REQ_READY;
    wire logic alter = live && (REQ_OP == FLP_OP_WRITE || REQ_OP == FLP_OP_WIPE);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    answer_once_a: assert property (live |-> ACC_GRANT ^ ACC_DENY)
        else $error("request not answered exactly once");
    quiet_early_a: assert property (!live |-> !ACC_GRANT && !ACC_DENY)
        else $error("answer without a ready request");
    fetch_start_a: assert property ($rose(RST_N) |-> !REQ_READY ##1 FL_RD_EN)
        else $error("lock fetch did not start after reset");
    fetch_order_a: assert property ($rose(FL_RD_EN) |-> FL_RD_ADDR == `FLP_LA_FCFG1
        ##1 FL_RD_EN && FL_RD_ADDR == `FLP_LA_CODE_LO
        ##1 FL_RD_EN && FL_RD_ADDR == `FLP_LA_CODE_HI
        ##1 FL_RD_EN && FL_RD_ADDR == `FLP_LA_UCFG
        ##1 FL_RD_EN && FL_RD_ADDR == `FLP_LA_FCFG2 ##1 !FL_RD_EN)
        else $error("lock fetch order wrong");
    ready_after_a: assert property ($fell(FL_RD_EN) |-> !REQ_READY ##1 REQ_READY)
        else $error("ready not one cycle after last fetch");
    no_refetch_a: assert property (REQ_READY |-> !FL_RD_EN ##1 REQ_READY)
        else $error("locks fetched again without reset");
    chip_cpu_a: assert property (live && REQ_OP == FLP_OP_CHIP && !REQ_PROG_MODE
        |-> ACC_DENY) else $error("chip erase granted in normal mode");
    factory_fixed_a: assert property (alter && REQ_ADDR inside {[16'h4000:16'h45FF]}
        |-> ACC_DENY) else $error("factory sector change granted");
    rom_fixed_a: assert property (alter && REQ_ADDR[15] |-> ACC_DENY)
        else $error("ROM change granted");
    // Test mode lifts the erase block, so only plain wipes and writes must fail
    last_page_a: assert property (live && MODE_LIMITED && REQ_ADDR[15:9] == 7'h1F
        && (REQ_OP == FLP_OP_WRITE || (REQ_OP == FLP_OP_WIPE && !REQ_TEST_MODE))
        |-> ACC_DENY) else $error("last page change granted under code lock");
    open_read_a: assert property (live && !MODE_LIMITED && REQ_OP == FLP_OP_READ
        && REQ_ADDR[15:14] == 2'h0 |-> ACC_GRANT) else $error("unlocked code read denied");
    limited_ready_a: assert property (MODE_LIMITED |-> REQ_READY)
        else $error("mode limit before locks loaded");

    cover property (live && ACC_DENY && MODE_LIMITED);
    cover property (live && REQ_OP == FLP_OP_CHIP && ACC_GRANT);
    cover property ($fell(FL_RD_EN));
    cover property (live && REQ_TEST_MODE && REQ_OP == FLP_OP_WIPE && ACC_GRANT);
endmodule

bind flp_lock_guard flp_lock_guard_checker i_flp_lock_guard_checker
(
    .CLK, .RST_N, .FL_RD_EN, .FL_RD_ADDR, .REQ_VALID, .REQ_OP, .REQ_ADDR,
    .REQ_PROG_MODE, .REQ_TEST_MODE, .REQ_READY, .ACC_GRANT, .ACC_DENY, .MODE_LIMITED
);

// File: sim/tb_flash_lock_byte_protection.sv
module tb_flash_lock_byte_protection;
    timeunit 1ns;
    timeprecision 100ps;

    // Lock set {user cfg, high side, low side, factory}; flags {prog, test, grant}
    typedef struct packed {
        logic [31:0] cfg;
        logic [1:0] op;
        logic [15:0] addr;
        logic [2:0] flg;
    } flp_tb_row_t;

    localparam logic [31:0] OPEN = 32'hFFFFFFFF;
    localparam logic [31:0] LOWB = 32'h00FFFE00;
    localparam logic [31:0] HITW = 32'hFFFDFFFF;

    logic CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, FL_RD_EN, MODE_LIMITED;
    logic REQ_VALID, REQ_PROG_MODE, REQ_TEST_MODE, REQ_READY, ACC_GRANT, ACC_DENY;
    logic [1:0] REQ_OP;
    logic [7:0] PADDR, FL_RD_DATA;
    logic [15:0] FL_RD_ADDR, REQ_ADDR;
    logic [31:0] PWDATA, PRDATA, cfg, rdata;
    logic err;
    logic act;
    logic bad;
    int failures, comparisons, cycles;

    flp_tb_row_t rows[$] = '{
        '{OPEN, 2'h0, 16'h0000, 3'h1}, '{OPEN, 2'h1, 16'h3E00, 3'h5},
        '{OPEN, 2'h2, 16'h0000, 3'h1}, '{OPEN, 2'h1, 16'h4610, 3'h1},
        '{OPEN, 2'h2, 16'h4600, 3'h5}, '{OPEN, 2'h3, 16'h0000, 3'h0},
        '{OPEN, 2'h3, 16'h0000, 3'h5}, '{OPEN, 2'h0, 16'h4000, 3'h1},
        '{OPEN, 2'h1, 16'h4000, 3'h4}, '{OPEN, 2'h2, 16'h4400, 3'h4},
        '{OPEN, 2'h0, 16'h8000, 3'h1}, '{OPEN, 2'h1, 16'h8000, 3'h4},
        '{OPEN, 2'h0, 16'h5000, 3'h0}, '{OPEN, 2'h1, 16'h0010, 3'h4},
        '{LOWB, 2'h1, 16'h0000, 3'h0}, '{LOWB, 2'h1, 16'h0200, 3'h1},
        '{LOWB, 2'h1, 16'h3E00, 3'h0}, '{LOWB, 2'h1, 16'h3C00, 3'h1},
        '{LOWB, 2'h0, 16'h0000, 3'h1}, '{LOWB, 2'h0, 16'h0000, 3'h4},
        '{LOWB, 2'h2, 16'h0200, 3'h0}, '{LOWB, 2'h2, 16'h0200, 3'h7},
        '{LOWB, 2'h0, 16'h4600, 3'h1}, '{LOWB, 2'h1, 16'h4600, 3'h4},
        '{LOWB, 2'h2, 16'h4600, 3'h0}, '{LOWB, 2'h2, 16'h4600, 3'h3},
        '{LOWB, 2'h0, 16'h4000, 3'h0}, '{LOWB, 2'h0, 16'h4400, 3'h0},
        '{LOWB, 2'h3, 16'h0000, 3'h5}, '{HITW, 2'h1, 16'h3A00, 3'h1},
        '{HITW, 2'h1, 16'h3C00, 3'h0}, '{HITW, 2'h1, 16'h0000, 3'h1},
        '{32'hFFFF80FF, 2'h1, 16'h3C00, 3'h0}, '{32'hFFFF7FFF, 2'h1, 16'h0200, 3'h0},
        '{32'hFF80FFFF, 2'h1, 16'h0000, 3'h0}};

    flp_lock_guard #(.APB_AW(8)) i_flp_lock_guard
    (
        .CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .FL_RD_EN, .FL_RD_ADDR, .FL_RD_DATA, .REQ_VALID, .REQ_OP, .REQ_ADDR,
        .REQ_PROG_MODE, .REQ_TEST_MODE, .REQ_READY, .ACC_GRANT, .ACC_DENY, .MODE_LIMITED
    );

    flp_flash_model i_flp_flash_model
    (
        .clk(CLK), .rd_en(FL_RD_EN), .rd_addr(FL_RD_ADDR), .locks(cfg), .rd_data(FL_RD_DATA)
    );

    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    task automatic final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Expected page mask; invalid codes lock everything
    function automatic logic [31:0] pmask(input logic [7:0] lo, input logic [7:0] hi);
        logic [31:0] m;
        m = 32'h0;
        for (int p = 0; p < 32; p++)
        begin
            if (lo != 8'hFF && (lo < 8'h80 || p <= 8'hFE - lo || p == 8'h1F))
                m[p] = 1'b1;
            if (hi != 8'hFF && (hi < 8'h80 || p + 8'hFE - hi >= 8'h1F))
                m[p] = 1'b1;
        end
        return m;
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        // Only the bench timeout ends a stuck wait
        do
        begin
            @(posedge CLK);
        end
        while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic do_reset(input logic [31:0] c);
        int n;
        @(posedge CLK);
        RST_N <= 1'b0;
        cfg <= c;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        n = 0;
        do
        begin
            @(negedge CLK);
            n++;
        end
        while (REQ_READY !== 1'b1 && n < 20);
        chk(n, 32'h8);
    endtask

    task automatic req(input logic [1:0] op, input logic [15:0] a, input logic [2:0] f);
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        REQ_OP <= op;
        REQ_ADDR <= a;
        REQ_PROG_MODE <= f[2];
        REQ_TEST_MODE <= f[1];
        @(negedge CLK);
        chk(32'(ACC_GRANT), 32'(f[0]));
        chk(32'(ACC_DENY), 32'(!f[0]));
    endtask

    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            final_report();
        end
    end

    initial
    begin
        RST_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        REQ_VALID = 1'b0;
        REQ_OP = 2'h0;
        REQ_ADDR = 16'h0;
        REQ_PROG_MODE = 1'b0;
        REQ_TEST_MODE = 1'b0;
        cfg = OPEN;
        foreach (rows[i])
        begin
            if (i == 0 || rows[i].cfg !== rows[i - 1].cfg)
            begin
                do_reset(rows[i].cfg);
                apb(1'b0, 8'h00, 32'h0, rdata, err);
                chk(rdata, rows[i].cfg);
                act = rows[i].cfg[23:8] != 16'hFFFF;
                bad = (rows[i].cfg[15:8] != 8'hFF && !rows[i].cfg[15])
                    || (rows[i].cfg[23:16] != 8'hFF && !rows[i].cfg[23]);
                apb(1'b0, 8'h04, 32'h0, rdata, err);
                chk(rdata, {20'h00000, act, bad, act, 1'b1, rows[i].cfg[7:0]});
                apb(1'b0, 8'h08, 32'h0, rdata, err);
                chk(rdata, pmask(rows[i].cfg[15:8], rows[i].cfg[23:16]));
            end
            req(rows[i].op, rows[i].addr, rows[i].flg);
            chk(32'(MODE_LIMITED), 32'(rows[i].cfg[23:8] != 16'hFFFF));
        end
        // New flash values must wait for a reset; a register write to the lock set is ignored
        apb(1'b1, 8'h00, OPEN, rdata, err);
        apb(1'b0, 8'h00, 32'h0, rdata, err);
        chk(rdata, 32'hFF80FFFF);
        cfg <= OPEN;
        req(2'h1, 16'h0200, 3'h0);
        apb(1'b0, 8'h0C, 32'h0, rdata, err);
        chk({rdata[31:16], 12'h000, rdata[3:0]}, 32'h0200_0003);
        REQ_VALID <= 1'b0;
        apb(1'b1, 8'h0C, 32'h1, rdata, err);
        apb(1'b0, 8'h0C, 32'h0, rdata, err);
        chk({31'h0, rdata[0]}, 32'h0);
        // Logging off: a deny must leave the sticky flag clear
        apb(1'b1, 8'h10, 32'h0, rdata, err);
        apb(1'b0, 8'h10, 32'h0, rdata, err);
        chk(rdata, 32'h0);
        req(2'h1, 16'h0200, 3'h0);
        apb(1'b0, 8'h0C, 32'h0, rdata, err);
        chk({31'h0, rdata[0]}, 32'h0);
        REQ_VALID <= 1'b0;
        apb(1'b0, 8'h14, 32'h0, rdata, err);
        chk({rdata[31:1], err}, 32'h1);
        do_reset(OPEN);
        req(2'h1, 16'h0200, 3'h1);
        final_report();
    end
endmodule
